// ===== dv/test_video_dac_sync_blank_control.sv
// Testbench for the sync, blank and video level control
`timescale 1ns/100ps
module test_video_dac_sync_blank_control;
  logic ref_clk = 1'b0;
  logic reset, hsel, hwrite, hreadyout, hresp, pix_valid, pix_ready, slow, fb;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [11:0] grn, red, blu;
  vdsc_pkg::vdsc_sample_t pw, vec[8];
  int fail_count = 0, tests_run = 0, cycles = 0, n;

  vdsc_top i_vdsc_top (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_green(pw.green), .pix_blue(pw.blue),
    .pix_red(pw.red), .pix_sync_n(pw.sync_n), .pix_sync_tri(pw.sync_tri),
    .pix_blank_n(pw.blank_n), .green_luma_output(grn),
    .red_cr_output(red), .blue_cb_output(blu));
  vdsc_source i_vdsc_source (.ref_clk(ref_clk), .reset(reset),
    .slow(slow), .pix_ready(pix_ready), .pix_valid(pix_valid),
    .pix_word(pw));

  always #20 ref_clk = ~ref_clk;

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      end_of_test;
    end
  end

  task tick;
    @(posedge ref_clk);
    #1;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  function automatic logic [11:0] lvl(input logic c,
    input vdsc_pkg::vdsc_sample_t s, input logic [7:0] code);
    logic [19:0] v;
    v = ({12'h000, code} * 20'h0074b + 20'h0007f) / 20'h000ff;
    if (!s.sync_n)
      return (c && s.sync_tri) ? 12'h640 : 12'h000;
    if (!s.blank_n || fb)
      return c ? 12'h320 : 12'h000;
    return v[11:0] + (c ? 12'h320 : 12'h000);
  endfunction

  initial
  begin
    vec = '{{8'hff, 8'hff, 8'hff, 3'b101}, {8'h00, 8'h00, 8'h00, 3'b101},
      {8'h55, 8'h80, 8'h12, 3'b110}, {8'h33, 8'h33, 8'h33, 3'b001},
      {8'h33, 8'h33, 8'h33, 3'b010}, {8'h00, 8'h00, 8'h00, 3'b000},
      {8'h80, 8'h40, 8'hc0, 3'b111}, {8'h00, 8'h00, 8'h00, 3'b101}};
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    slow = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    bus(1'b0, vdsc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
    for (int sa = 0; sa < 3; sa++)
    begin
      slow <= sa[0];
      fb = sa[1];
      bus(1'b1, vdsc_pkg::ADDR_CTRL, {29'h0, sa[1], sa[0], 1'b0});
      for (int i = 0; i < 8; i++)
        i_vdsc_source.push(vec[i]);
      for (n = 0; n < 60 && pix_ready !== 1'b0; n++)
        tick;
      chk(32'(pix_ready), 32'h0);
      bus(1'b0, vdsc_pkg::ADDR_STATUS, 32'h0);
      chk({28'h0, rd[7:4]}, 32'h8);
      bus(1'b1, vdsc_pkg::ADDR_CTRL, {29'h0, sa[1], sa[0], 1'b1});
      // Run lands, state enters run, first sample reaches the pins
      repeat (2) tick;
      for (int i = 0; i < 8; i++)
      begin
        chk(32'(grn), 32'(lvl(1'b1, vec[i], vec[i].green)));
        chk(32'(red), 32'(lvl(sa[0], vec[i], vec[i].red)));
        chk(32'(blu), 32'(lvl(sa[0], vec[i], vec[i].blue)));
        tick;
      end
      chk(32'(red), sa[0] ? 32'h0000_0320 : 32'h0);
      bus(1'b1, vdsc_pkg::ADDR_CTRL, {29'h0, sa[1], sa[0], 1'b0});
      bus(1'b0, vdsc_pkg::ADDR_COUNT, 32'h0);
      chk(rd, 32'h8);
      bus(1'b1, vdsc_pkg::ADDR_COUNT, 32'h0);
      bus(1'b0, vdsc_pkg::ADDR_COUNT, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, vdsc_pkg::ADDR_STATUS, 32'h1);
      bus(1'b0, vdsc_pkg::ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      $display("batch %0d done", sa);
    end
    end_of_test;
  end
endmodule

// ===== dv/vdsc_source.sv
// Video source model feeding samples to the level control
`timescale 1ns/100ps
module vdsc_source (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic pix_ready,
  output logic pix_valid,
  output vdsc_pkg::vdsc_sample_t pix_word
);
  vdsc_pkg::vdsc_sample_t q[$];
  initial pix_word = '0;
  task push(input vdsc_pkg::vdsc_sample_t s);
    q.push_back(s);
  endtask
  // Hold each sample until taken; idle data lines toggle
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      pix_valid <= 1'b0;
    end
    else if (!pix_valid || pix_ready)
    begin
      if (q.size() > 0 && !(slow && pix_valid))
      begin
        pix_valid <= 1'b1;
        pix_word <= q.pop_front();
      end
      else
      begin
        pix_valid <= 1'b0;
        pix_word <= ~pix_word;
      end
    end
  end
endmodule

// ===== dv/vdsc_top_asserts.sv
// Assertions on the level control's bus and output pins
`timescale 1ns/100ps
module vdsc_top_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [11:0] green_luma_output,
  input wire logic [11:0] red_cr_output,
  input wire logic [11:0] blue_cb_output
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  wire rd_tk = hsel && htrans[1] && hready && !hwrite;

  a_no_wait: assert property (hreadyout)
    else $error("bus slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("bus response not okay");
  a_tri_all: assert property (red_cr_output == 12'h640 |->
    green_luma_output == 12'h640 && blue_cb_output == 12'h640)
    else $error("positive sync level differs between channels");
  a_neg_all: assert property (green_luma_output == 12'h000 |->
    red_cr_output == 12'h000 && blue_cb_output == 12'h000)
    else $error("negative sync level differs between channels");
  a_green_floor: assert property (green_luma_output != 12'h000 &&
    green_luma_output != 12'h640 |-> green_luma_output >= 12'h320
    && green_luma_output <= 12'ha6b)
    else $error("green output outside video range");
  a_unmapped_zero: assert property (rd_tk && haddr[7:0] == 8'h0c
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
  a_status_resv: assert property (rd_tk && haddr[7:0] == 8'h04 |=>
    hrdata[31:8] == 24'h00_0000 && hrdata[3:2] == 2'h0
    && hrdata[7:4] <= 4'h8)
    else $error("status reserved bits or level wrong");
  a_rdata_hold: assert property (!rd_tk |=> $stable(hrdata))
    else $error("read data changed without a read");
endmodule

bind vdsc_top vdsc_top_asserts i_vdsc_top_asserts (.ref_clk(ref_clk),
  .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .green_luma_output(green_luma_output),
  .red_cr_output(red_cr_output), .blue_cb_output(blue_cb_output));

// ===== rtl/vdsc_fifo.sv
// Sample FIFO with registered read data and registered ready
`timescale 1ns/100ps
module vdsc_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8,
  parameter int LVL_W = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  vdsc_fifo_if.fifo port
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [LVL_W-1:0] FULL = LVL_W'(DEPTH);
  localparam logic [LVL_W-1:0] ONE = LVL_W'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [LVL_W-1:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
    logic in_ready;
  } vdsc_fifo_state_t;

  vdsc_fifo_state_t s_q;
  vdsc_fifo_state_t s_d;
  logic push;
  logic load;

  always_comb
  begin
    s_d = s_q;
    push = port.wr_valid && s_q.in_ready;
    load = (s_q.count != '0) && (!s_q.out_valid || port.rd_ready);
    if (push)
    begin
      s_d.mem[s_q.wptr] = port.wr_data;
      s_d.wptr = s_q.wptr + PTR_W'(1);
    end
    if (load)
    begin
      s_d.out_data = s_q.mem[s_q.rptr];
      s_d.rptr = s_q.rptr + PTR_W'(1);
      s_d.out_valid = 1'b1;
    end
    else if (port.rd_ready)
    begin
      s_d.out_valid = 1'b0;
    end
    if (push && !load)
    begin
      s_d.count = s_q.count + ONE;
    end
    else if (load && !push)
    begin
      s_d.count = s_q.count - ONE;
    end
    // Output register holds one of the words
    s_d.in_ready = ((s_d.count + LVL_W'(s_d.out_valid)) != FULL);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign port.wr_ready = s_q.in_ready;
  assign port.rd_valid = s_q.out_valid;
  assign port.rd_data = s_q.out_data;
  assign port.level = s_q.count + LVL_W'(s_q.out_valid);
endmodule

// ===== rtl/vdsc_fifo_if.sv
// Carrier between the level control and its sample FIFO
`timescale 1ns/100ps
interface vdsc_fifo_if #(
  parameter int WIDTH = 27,
  parameter int LVL_W = 4
);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  logic [LVL_W-1:0] level;

  modport fifo (
    input wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data, level
  );

  modport user (
    output wr_valid, wr_data, rd_ready,
    input wr_ready, rd_valid, rd_data, level
  );
endinterface

// ===== rtl/vdsc_pkg.sv
// Constants and types for the video DAC sync and blank level control
package vdsc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam int ADDR_W = 8;

  // Control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SYNC_ALL = 1;
  localparam int CTRL_FORCE_BLANK = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register fields
  localparam int STAT_UNDERRUN = 0;
  localparam int STAT_RUNNING = 1;
  localparam int STAT_LEVEL_LSB = 4;
  localparam int STAT_LEVEL_W = 4;

  // Sample word layout
  localparam int CODE_W = 8;
  localparam int SAMPLE_W = 27;
  localparam int FIFO_DEPTH = 8;
  localparam int LEVEL_W = 4;

  // Output currents in units of 10 uA
  localparam int CUR_W = 12;
  localparam logic [CUR_W-1:0] CUR_ZERO = 12'h000;
  localparam logic [CUR_W-1:0] CUR_SETUP = 12'h320;
  localparam logic [CUR_W-1:0] CUR_SYNC_POS = 12'h640;
  localparam logic [CUR_W-1:0] CUR_SYNC_NEG = 12'h000;
  localparam int PROD_W = 20;
  localparam logic [PROD_W-1:0] CUR_FS = 20'h0074b;
  localparam logic [PROD_W-1:0] CODE_MAX = 20'h000ff;
  localparam logic [PROD_W-1:0] CODE_HALF = 20'h0007f;

  typedef struct packed {
    logic [CODE_W-1:0] green;
    logic [CODE_W-1:0] blue;
    logic [CODE_W-1:0] red;
    logic sync_n;
    logic sync_tri;
    logic blank_n;
  } vdsc_sample_t;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run = 2'b10
  } vdsc_run_st_t;

endpackage

// ===== rtl/vdsc_top.sv
// Sync, blank and video level selection for a triple video DAC
`timescale 1ns/100ps
module vdsc_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [7:0] pix_green,
  input wire logic [7:0] pix_blue,
  input wire logic [7:0] pix_red,
  input wire logic pix_sync_n,
  input wire logic pix_sync_tri,
  input wire logic pix_blank_n,
  output logic [11:0] green_luma_output,
  output logic [11:0] red_cr_output,
  output logic [11:0] blue_cb_output
);

  typedef struct packed {
    logic wr_pend;
    logic [vdsc_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic readyout;
    logic resp;
    logic run;
    logic sync_all;
    logic force_blank;
    logic underrun;
    vdsc_pkg::vdsc_run_st_t st;
    logic [31:0] count;
    logic [vdsc_pkg::CUR_W-1:0] green;
    logic [vdsc_pkg::CUR_W-1:0] red;
    logic [vdsc_pkg::CUR_W-1:0] blue;
  } vdsc_top_state_t;

  vdsc_top_state_t s_q;
  vdsc_top_state_t s_d;

  vdsc_fifo_if #(
    .WIDTH(vdsc_pkg::SAMPLE_W),
    .LVL_W(vdsc_pkg::LEVEL_W)
  ) fifo_bus ();

  vdsc_fifo #(
    .WIDTH(vdsc_pkg::SAMPLE_W),
    .DEPTH(vdsc_pkg::FIFO_DEPTH),
    .LVL_W(vdsc_pkg::LEVEL_W)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .port(fifo_bus.fifo)
  );

  vdsc_pkg::vdsc_sample_t in_sample;
  vdsc_pkg::vdsc_sample_t head;

  // Data and controls of one sample travel as one word
  always_comb
  begin
    in_sample.green = pix_green;
    in_sample.blue = pix_blue;
    in_sample.red = pix_red;
    in_sample.sync_n = pix_sync_n;
    in_sample.sync_tri = pix_sync_tri;
    in_sample.blank_n = pix_blank_n;
  end

  assign fifo_bus.wr_valid = pix_valid;
  assign fifo_bus.wr_data = in_sample;

  // Samples drain only while running
  logic running;
  assign running = (s_q.st == vdsc_pkg::st_run);
  assign fifo_bus.rd_ready = running;
  assign head = vdsc_pkg::vdsc_sample_t'(fifo_bus.rd_data);

  // Current for one channel from one sample
  function automatic logic [vdsc_pkg::CUR_W-1:0] chan_level(
    input logic carries_sync,
    input logic [vdsc_pkg::CODE_W-1:0] code,
    input logic sync_n,
    input logic sync_tri,
    input logic blank_n
  );
    logic [vdsc_pkg::CUR_W-1:0] base;
    logic [vdsc_pkg::PROD_W-1:0] prod;
    logic [vdsc_pkg::PROD_W-1:0] video;
    base = carries_sync ? vdsc_pkg::CUR_SETUP : vdsc_pkg::CUR_ZERO;
    prod = vdsc_pkg::PROD_W'(code) * vdsc_pkg::CUR_FS;
    video = (prod + vdsc_pkg::CODE_HALF) / vdsc_pkg::CODE_MAX;
    if (!sync_n)
    begin
      if (!carries_sync)
      begin
        chan_level = base;
      end
      else if (sync_tri)
      begin
        chan_level = vdsc_pkg::CUR_SYNC_POS;
      end
      else
      begin
        chan_level = vdsc_pkg::CUR_SYNC_NEG;
      end
    end
    else if (!blank_n)
    begin
      chan_level = base;
    end
    else
    begin
      chan_level = base + video[vdsc_pkg::CUR_W-1:0];
    end
  endfunction

  logic addr_phase;
  logic [vdsc_pkg::ADDR_W-1:0] addr_lo;
  logic [31:0] ctrl_view;
  logic [31:0] status_view;
  logic [31:0] read_mux;
  logic pop;
  logic side_sync;
  logic blank_n_eff;
  logic underrun_set;
  logic underrun_clr;
  logic count_clr;

  // One level path per channel: green/luma, red/cr, blue/cb
  localparam int NUM_CHAN = 3;
  logic [vdsc_pkg::CODE_W-1:0] chan_code [NUM_CHAN];
  logic chan_sync [NUM_CHAN];
  logic [vdsc_pkg::CUR_W-1:0] chan_lvl [NUM_CHAN];
  logic [vdsc_pkg::CUR_W-1:0] chan_idle [NUM_CHAN];

  assign side_sync = s_q.sync_all;
  assign blank_n_eff = head.blank_n && !s_q.force_blank;

  always_comb
  begin
    chan_code[0] = head.green;
    chan_code[1] = head.red;
    chan_code[2] = head.blue;
  end

  // Green/luma always carries sync, the others only when selected
  always_comb
  begin
    chan_sync[0] = 1'b1;
    chan_sync[1] = side_sync;
    chan_sync[2] = side_sync;
  end

  // Level per channel
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_chan
    always_comb
    begin
      chan_lvl[c] = chan_level(chan_sync[c], chan_code[c], head.sync_n,
        head.sync_tri, blank_n_eff);
      // Idle and underrun show blank on the sync channels
      chan_idle[c] = chan_sync[c] ? vdsc_pkg::CUR_SETUP : vdsc_pkg::CUR_ZERO;
    end
  end

  always_comb
  begin
    addr_phase = hsel && htrans[1] && hready;
    addr_lo = haddr[vdsc_pkg::ADDR_W-1:0];
    ctrl_view = '0;
    ctrl_view[vdsc_pkg::CTRL_RUN] = s_q.run;
    ctrl_view[vdsc_pkg::CTRL_SYNC_ALL] = s_q.sync_all;
    ctrl_view[vdsc_pkg::CTRL_FORCE_BLANK] = s_q.force_blank;
    status_view = '0;
    status_view[vdsc_pkg::STAT_UNDERRUN] = s_q.underrun;
    status_view[vdsc_pkg::STAT_RUNNING] = (s_q.st == vdsc_pkg::st_run);
    status_view[vdsc_pkg::STAT_LEVEL_LSB +: vdsc_pkg::STAT_LEVEL_W] =
      fifo_bus.level;
    unique case (addr_lo)
      vdsc_pkg::ADDR_CTRL:
      begin
        read_mux = ctrl_view;
      end
      vdsc_pkg::ADDR_STATUS:
      begin
        read_mux = status_view;
      end
      vdsc_pkg::ADDR_COUNT:
      begin
        read_mux = s_q.count;
      end
      default:
      begin
        read_mux = '0;
      end
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    pop = fifo_bus.rd_valid && running;
    underrun_set = running && !fifo_bus.rd_valid;
    underrun_clr = 1'b0;
    count_clr = 1'b0;

    // Bus slave: zero wait, always OKAY
    s_d.readyout = 1'b1;
    s_d.resp = 1'b0;
    s_d.wr_pend = addr_phase && hwrite;
    if (addr_phase)
    begin
      s_d.wr_addr = addr_lo;
    end
    if (addr_phase && !hwrite)
    begin
      s_d.rdata = read_mux;
    end

    // Register writes land in the data phase
    if (s_q.wr_pend)
    begin
      unique case (s_q.wr_addr)
        vdsc_pkg::ADDR_CTRL:
        begin
          s_d.run = hwdata[vdsc_pkg::CTRL_RUN];
          s_d.sync_all = hwdata[vdsc_pkg::CTRL_SYNC_ALL];
          s_d.force_blank = hwdata[vdsc_pkg::CTRL_FORCE_BLANK];
        end
        vdsc_pkg::ADDR_STATUS:
        begin
          underrun_clr = hwdata[vdsc_pkg::STAT_UNDERRUN];
        end
        vdsc_pkg::ADDR_COUNT:
        begin
          count_clr = 1'b1;
        end
        default:
        begin
          underrun_clr = 1'b0;
        end
      endcase
    end

    // Sticky underrun, set beats clear
    if (underrun_set)
    begin
      s_d.underrun = 1'b1;
    end
    else if (underrun_clr)
    begin
      s_d.underrun = 1'b0;
    end

    // Sample counter, a clear in the same cycle as a taken sample leaves one
    if (pop)
    begin
      s_d.count = (count_clr ? 32'h0000_0000 : s_q.count) + 32'h0000_0001;
    end
    else if (count_clr)
    begin
      s_d.count = 32'h0000_0000;
    end

    // Run control
    unique case (s_q.st)
      vdsc_pkg::st_idle:
      begin
        if (s_q.run)
        begin
          s_d.st = vdsc_pkg::st_run;
        end
      end
      vdsc_pkg::st_run:
      begin
        if (!s_q.run)
        begin
          s_d.st = vdsc_pkg::st_idle;
        end
      end
      default:
      begin
        s_d.st = vdsc_pkg::st_idle;
      end
    endcase

    // Output levels
    if (pop)
    begin
      s_d.green = chan_lvl[0];
      s_d.red = chan_lvl[1];
      s_d.blue = chan_lvl[2];
    end
    else
    begin
      s_d.green = chan_idle[0];
      s_d.red = chan_idle[1];
      s_d.blue = chan_idle[2];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q.wr_pend <= 1'b0;
      s_q.wr_addr <= '0;
      s_q.rdata <= 32'h0000_0000;
      s_q.readyout <= 1'b1;
      s_q.resp <= 1'b0;
      s_q.run <= vdsc_pkg::CTRL_RESET[vdsc_pkg::CTRL_RUN];
      s_q.sync_all <= vdsc_pkg::CTRL_RESET[vdsc_pkg::CTRL_SYNC_ALL];
      s_q.force_blank <= vdsc_pkg::CTRL_RESET[vdsc_pkg::CTRL_FORCE_BLANK];
      s_q.underrun <= 1'b0;
      s_q.st <= vdsc_pkg::st_idle;
      s_q.count <= 32'h0000_0000;
      s_q.green <= vdsc_pkg::CUR_SETUP;
      s_q.red <= vdsc_pkg::CUR_ZERO;
      s_q.blue <= vdsc_pkg::CUR_ZERO;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.readyout;
  assign hrdata = s_q.rdata;
  assign hresp = s_q.resp;
  assign pix_ready = fifo_bus.wr_ready;
  assign green_luma_output = s_q.green;
  assign red_cr_output = s_q.red;
  assign blue_cb_output = s_q.blue;

endmodule
